// ==== core/fsps_consts.vh ====
// Constants for the flash self-program sequencer.
// Included by the sequencer and the bench; definitions only.
`ifndef FSPS_CONSTS_VH
`define FSPS_CONSTS_VH

// ****************************************
// Register map (APB byte addresses)
// ****************************************
`define FSPS_ADDR_CTRL 12'h000
`define FSPS_ADDR_PTR 12'h004
`define FSPS_ADDR_DATA 12'h008
`define FSPS_ADDR_CMD 12'h00C
`define FSPS_ADDR_LPMD 12'h010
`define FSPS_ADDR_STAT 12'h014
`define FSPS_ADDR_FUSE 12'h018
`define FSPS_ADDR_LOCK 12'h01C

// ****************************************
// Control register fields and patterns
// ****************************************
`define FSPS_BIT_EN 0
`define FSPS_BIT_ERS 1
`define FSPS_BIT_WRT 2
`define FSPS_BIT_LCK 3
`define FSPS_BIT_REEN 4
`define FSPS_BIT_BUSY 6
`define FSPS_BIT_IE 7
`define FSPS_PAT_LOAD 5'h01
`define FSPS_PAT_ERASE 5'h03
`define FSPS_PAT_WRITE 5'h05
`define FSPS_PAT_LOCK 5'h09
`define FSPS_PAT_REEN 5'h11

// ****************************************
// Command port codes (CMD register)
// ****************************************
`define FSPS_CMD_STORE 2'h1
`define FSPS_CMD_LOAD 2'h2

// ****************************************
// Addresses and reset values
// ****************************************
`define FSPS_PTR_FUSE_LO 16'h0000
`define FSPS_PTR_LOCK 16'h0001
`define FSPS_PTR_FUSE_EXT 16'h0002
`define FSPS_PTR_FUSE_HI 16'h0003
`define FSPS_RST_FUSE 24'hFFFFFF
`define FSPS_RST_LOCK 6'h3F

// ****************************************
// Timing
// ****************************************
`define FSPS_STORE_WIN 3'h4
`define FSPS_LOAD_WIN 3'h3
`define FSPS_CLK_KHZ 40000
`define FSPS_PROG_MIN_US 3700
`define FSPS_PROG_MAX_US 4500

`endif

// ==== core/fsps_page_buffer.v ====
// Page buffer holding one flash page of 16-bit words.
// Assumes single clock pclk, async active-low reset.
`timescale 1ns/1ps
`default_nettype none

module fsps_page_buffer #(
   parameter WORD_BITS = 5
) (
   input wire pclk,
   input wire presetn,
   input wire clear,
   input wire wr_en,
   input wire [WORD_BITS-1:0] wr_slot,
   input wire [15:0] wr_data,
   input wire [WORD_BITS-1:0] rd_slot,
   output wire [15:0] rd_data,
   output reg [(1<<WORD_BITS)-1:0] filled
);
   reg [15:0] mem [0:(1<<WORD_BITS)-1];

   // ****************************************
   // Storage; cleared slots read as erased ones
   // ****************************************
   always @(posedge pclk) begin
      if (wr_en)
         mem[wr_slot] <= wr_data;
   end

   assign rd_data = filled[rd_slot] ? mem[rd_slot] : 16'hFFFF;

   // Fill marks; clear wins, data array itself needs no reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filled <= {(1<<WORD_BITS){1'b0}};
      end else if (clear) begin
         filled <= {(1<<WORD_BITS){1'b0}};
      end else if (wr_en) begin
         filled[wr_slot] <= 1'b1;
      end
   end
endmodule // fsps_page_buffer

`default_nettype wire

// ==== core/fsps_sequencer.v ====
// Flash self-program sequencer: control register, page buffer,
// erase/write/lock timing, fuse and lock read-back, over APB.
// Assumes APB master on pclk; eeprom_busy pin is asynchronous.
//
// Contract
// R1 - Write only erased pages; buffer loads any order
// R2 - Software uses same page for erase, write
// R3 - X0000011 plus store in four cycles erases
// R4 - Stall CPU while erasing no-read-while-write section
// R5 - 00000001 plus store loads data word slot
// R6 - Buffer clears on write, re-enable, reset
// R7 - Software loads each slot once per clear
// R8 - EEPROM write during loading discards buffer
// R9 - X0000101 plus store writes page from buffer
// R10 - Stall CPU while writing no-read-while-write section
// R11 - Interrupt held while enable enabled, enable bit zero
// R12 - Section reads blocked, busy flag while busy
// R13 - Software re-enables section before reading again
// R14 - X0001001 plus store sets boot lock bits
// R15 - Zero data bits 5..2 program boot locks
// R16 - Software uses pointer 0x0001, ones elsewhere
// R17 - EEPROM write blocks programming and fuse reads
// R18 - Software checks EEPROM busy before control write
// R19 - Pointer 0x0001 load in three returns locks
// R20 - Lock-set and enable clear on read, timeout
// R21 - Pointers 0, 3, 2 return fuse bytes
// R22 - Programmed bits read zero, unprogrammed one
// R23 - Enable clears after store or four idle cycles
// R24 - Undefined low five bit patterns do nothing
// R25 - Program operations last 3.7 to 4.5 ms
// R26 - Buffer depth, pointer split are parameters
`timescale 1ns/1ps
`default_nettype none
`include "fsps_consts.vh"

module fsps_sequencer #(
   parameter WORD_BITS = 5,
   parameter PAGE_BITS = 7,
   parameter NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h60,
   parameter PROG_CYCLES = 148000
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire eeprom_write_busy,
   output reg cpu_stall,
   output reg section_read_block,
   output reg completion_irq,
   output reg flash_erase_strobe,
   output reg flash_write_strobe,
   output reg [PAGE_BITS-1:0] flash_page
);
   // Minimum programming time in cycles, clock truncated to whole MHz
   localparam MIN_CYCLES =
      (`FSPS_PROG_MIN_US * (`FSPS_CLK_KHZ / 1000) + 0);
   localparam ST_IDLE = 2'h0;
   localparam ST_PROG = 2'h1;
   localparam OP_ERASE = 2'h0;
   localparam OP_WRITE = 2'h1;
   localparam OP_LOCK = 2'h2;

   reg [7:0] ctrl;
   reg [15:0] ptr;
   reg [15:0] data_pair;
   reg [7:0] lpm_data;
   reg [1:0] state;
   reg [1:0] op;
   reg [17:0] timer;
   reg [PAGE_BITS-1:0] busy_page;
   reg [23:0] fuse_bits;
   reg [5:0] lock_bits;
   reg ee_meta;
   reg ee_sync;
   reg [(1<<PAGE_BITS)-1:0] erased;

   wire [WORD_BITS-1:0] word_field = ptr[WORD_BITS:1]; // [R26]
   wire [PAGE_BITS-1:0] page_field = ptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
   wire [31:0] wr_prev;
   wire setup_ok = psel && penable && pready;
   wire wr_acc = setup_ok && pwrite;
   wire rd_acc = setup_ok && !pwrite;
   wire ctrl_wr = wr_acc && (paddr == `FSPS_ADDR_CTRL);
   wire cmd_wr = wr_acc && (paddr == `FSPS_ADDR_CMD);
   wire store_ins = cmd_wr && (pwdata[1:0] == `FSPS_CMD_STORE);
   wire load_ins = cmd_wr && (pwdata[1:0] == `FSPS_CMD_LOAD);
   wire [4:0] new_pat = pwdata[4:0];
   wire pat_ok = (new_pat == `FSPS_PAT_LOAD) ||
      (new_pat == `FSPS_PAT_ERASE) || (new_pat == `FSPS_PAT_WRITE) ||
      (new_pat == `FSPS_PAT_LOCK) || (new_pat == `FSPS_PAT_REEN);
   // Control writes blocked while flash busy or EEPROM writing
   wire ctrl_take = ctrl_wr && (state == ST_IDLE) && pat_ok &&
      !ee_sync; // [R17] [R24]
   wire [4:0] armed = ctrl[4:0];
   wire store_win;
   wire store_exp;
   wire load_win;
   wire load_exp;
   wire [15:0] buf_rd;
   wire [(1<<WORD_BITS)-1:0] buf_filled;
   wire do_store = store_ins && store_win && (state == ST_IDLE);
   wire do_load_buf = do_store && (armed == `FSPS_PAT_LOAD);
   wire do_erase = do_store && (armed == `FSPS_PAT_ERASE);
   wire do_write = do_store && (armed == `FSPS_PAT_WRITE) &&
      erased[page_field]; // [R1]
   wire do_lock = do_store && (armed == `FSPS_PAT_LOCK);
   wire do_reen = do_store && (armed == `FSPS_PAT_REEN);
   wire do_read = load_ins && load_win && (armed == `FSPS_PAT_LOCK);
   wire prog_done = (state == ST_PROG) && (timer == 18'h0);
   wire no_read_while_write_section_hit = (page_field >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
   // Buffer loss: page written, re-enable, or EEPROM during loading
   wire buf_clear = (prog_done && (op == OP_WRITE)) || do_reen ||
      (ee_sync && (buf_filled != 0)); // [R6] [R8]

   assign wr_prev = 32'h0;

   // ****************************************
   // Windows for store and load instructions
   // ****************************************
   fsps_window u_store_win (
      .pclk(pclk),
      .presetn(presetn),
      .start(ctrl_take),
      .length(`FSPS_STORE_WIN),
      .stop(do_store),
      .open(store_win),
      .expired(store_exp)
   );

   fsps_window u_load_win (
      .pclk(pclk),
      .presetn(presetn),
      .start(ctrl_take && (new_pat == `FSPS_PAT_LOCK)),
      .length(`FSPS_LOAD_WIN),
      .stop(do_read),
      .open(load_win),
      .expired(load_exp)
   );

   // ****************************************
   // Page buffer, depth set by WORD_BITS
   // ****************************************
   fsps_page_buffer #(
      .WORD_BITS(WORD_BITS)
   ) u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .clear(buf_clear), // [R6]
      .wr_en(do_load_buf && !ee_sync), // [R5]
      .wr_slot(word_field),
      .wr_data(data_pair),
      .rd_slot(word_field),
      .rd_data(buf_rd),
      .filled(buf_filled)
   );

   // ****************************************
   // EEPROM busy pin synchroniser
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ee_meta <= 1'b0;
         ee_sync <= 1'b0;
      end else begin
         ee_meta <= eeprom_write_busy;
         ee_sync <= ee_meta;
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   // Low bits stay set through programming, clear on any completion
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 8'h00;
      end else begin
         if (ctrl_wr && !ee_sync)
            ctrl[`FSPS_BIT_IE] <= pwdata[`FSPS_BIT_IE];
         if (ctrl_take)
            ctrl[4:0] <= new_pat; // [R24]
         else if (prog_done)
            ctrl[4:0] <= 5'h00; // [R23]
         else if (do_read)
            ctrl[4:0] <= 5'h00; // [R20]
         else if (do_store && !(do_erase || do_write || do_lock))
            ctrl[4:0] <= 5'h00; // [R23]
         else if (store_exp && !(load_win && armed == `FSPS_PAT_LOCK))
            ctrl[4:0] <= 5'h00; // [R20] [R23]
         else if (load_exp && !store_win)
            ctrl[4:0] <= 5'h00; // [R20]
         // Busy flag: set on section program, re-enable or buffer load clears it
         if ((do_erase || do_write) && !no_read_while_write_section_hit && !ee_sync)
            ctrl[`FSPS_BIT_BUSY] <= 1'b1; // [R12]
         else if ((do_reen || do_load_buf) && state == ST_IDLE)
            ctrl[`FSPS_BIT_BUSY] <= 1'b0;
      end
   end

   // ****************************************
   // Operation sequencer and timer
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         op <= OP_ERASE;
         timer <= 18'h0;
         busy_page <= {PAGE_BITS{1'b0}};
      end else begin
         case (state)
            ST_IDLE: begin
               if ((do_erase || do_write || do_lock) && !ee_sync) begin
                  state <= ST_PROG; // [R3] [R9] [R14]
                  op <= do_erase ? OP_ERASE :
                     (do_write ? OP_WRITE : OP_LOCK);
                  timer <= PROG_CYCLES[17:0] - 18'h1; // [R25]
                  busy_page <= page_field; // Address latched at start
               end
            end
            ST_PROG: begin
               if (timer == 18'h0)
                  state <= ST_IDLE;
               else
                  timer <= timer - 18'h1;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Flash array model state: erased pages and fuses
   // ****************************************
   // Lock bits: zero in data bits 5..2 programs that boot lock bit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erased <= {(1<<PAGE_BITS){1'b0}};
         fuse_bits <= `FSPS_RST_FUSE;
         lock_bits <= `FSPS_RST_LOCK;
      end else if (prog_done) begin
         if (op == OP_ERASE)
            erased[busy_page] <= 1'b1; // [R1]
         else if (op == OP_WRITE)
            erased[busy_page] <= 1'b0; // [R1]
         else
            lock_bits[5:2] <= lock_bits[5:2] & data_pair[5:2]; // [R15]
      end
   end

   // ****************************************
   // Flash-side outputs and CPU stall
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_stall <= 1'b0;
         section_read_block <= 1'b0;
         completion_irq <= 1'b0;
         flash_erase_strobe <= 1'b0;
         flash_write_strobe <= 1'b0;
         flash_page <= {PAGE_BITS{1'b0}};
      end else begin
         // Halt the CPU for whole erase/write of its own section
         if ((do_erase || do_write) && no_read_while_write_section_hit && !ee_sync)
            cpu_stall <= 1'b1; // [R4] [R10]
         else if (prog_done)
            cpu_stall <= 1'b0;
         section_read_block <= ctrl[`FSPS_BIT_BUSY]; // [R12]
         completion_irq <= ctrl[`FSPS_BIT_IE] &&
            !ctrl[`FSPS_BIT_EN]; // [R11]
         flash_erase_strobe <= prog_done && (op == OP_ERASE);
         flash_write_strobe <= prog_done && (op == OP_WRITE);
         if ((do_erase || do_write) && !ee_sync)
            flash_page <= page_field; // Same edge as the stall
      end
   end

   // ****************************************
   // Fuse and lock read-back
   // ****************************************
   // Stored as programmed=0, so read value passes straight out
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lpm_data <= 8'h00;
      end else if (do_read && !ee_sync) begin // [R17]
         case (ptr)
            `FSPS_PTR_LOCK: lpm_data <= {2'h3, lock_bits}; // [R19] [R22]
            `FSPS_PTR_FUSE_LO: lpm_data <= fuse_bits[7:0]; // [R21]
            `FSPS_PTR_FUSE_HI: lpm_data <= fuse_bits[15:8]; // [R21]
            `FSPS_PTR_FUSE_EXT: lpm_data <= {4'hF, fuse_bits[19:16]};
            default: lpm_data <= 8'hFF;
         endcase
      end else if (load_ins && !load_win) begin
         lpm_data <= buf_rd[7:0]; // Plain load reads buffer low byte
      end
   end

   // ****************************************
   // APB slave: pointer, data, readback
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr <= 16'h0000;
         data_pair <= 16'h0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && !pready; // No wait states; ready in first access cycle
         pslverr <= 1'b0;
         if (wr_acc && paddr == `FSPS_ADDR_PTR && state == ST_IDLE)
            ptr <= pwdata[15:0];
         if (wr_acc && paddr == `FSPS_ADDR_DATA && state == ST_IDLE)
            data_pair <= pwdata[15:0];
         if (psel && !penable) begin
            pslverr <= 1'b0;
            case (paddr)
               `FSPS_ADDR_CTRL: prdata <= {24'h0, ctrl};
               `FSPS_ADDR_PTR: prdata <= {16'h0, ptr};
               `FSPS_ADDR_DATA: prdata <= {16'h0, data_pair};
               `FSPS_ADDR_CMD: prdata <= wr_prev;
               `FSPS_ADDR_LPMD: prdata <= {24'h0, lpm_data};
               `FSPS_ADDR_STAT: prdata <= {29'h0, ee_sync,
                  (state == ST_PROG), cpu_stall};
               `FSPS_ADDR_FUSE: prdata <= {8'h0, fuse_bits};
               `FSPS_ADDR_LOCK: prdata <= {26'h0, lock_bits};
               default: begin
                  prdata <= 32'h0;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // fsps_sequencer

`default_nettype wire

// ==== core/fsps_window.v ====
// Countdown that opens a window of a few cycles for one instruction.
// Assumes single clock pclk, async active-low reset.
`timescale 1ns/1ps
`default_nettype none

module fsps_window (
   input wire pclk,
   input wire presetn,
   input wire start,
   input wire [2:0] length,
   input wire stop,
   output wire open,
   output wire expired
);
   reg [2:0] count;

   // ****************************************
   // Counter; start wins over stop
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         count <= 3'h0;
      else if (start)
         count <= length;
      else if (stop)
         count <= 3'h0;
      else if (count != 3'h0)
         count <= count - 3'h1;
   end

   assign open = (count != 3'h0);
   assign expired = (count == 3'h1) && !stop && !start;
endmodule // fsps_window

`default_nettype wire

// ==== tb/fsps_cpu_model.sv ====
// CPU-side model: register and instruction accesses as APB transfers.
// Assumes the sequencer answers on pclk; the bench calls xfer.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// CPU model
// ****************************************
module fsps_cpu_model (
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
   end

   // One transfer; ok low if no answer within 51 edges of penable
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] rd,
         output logic err, output logic ok);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      ok = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines carry junk, not the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // fsps_cpu_model

`default_nettype wire

// ==== tb/fsps_seq_chk.sv ====
// Port checker for the flash self-program sequencer.
// Assumes a bind onto fsps_sequencer; one clock pclk, reset presetn.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Checker
// ****************************************
module fsps_seq_chk #(
   parameter PAGE_BITS = 7,
   parameter NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h60,
   parameter PROG_CYCLES = 148000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpu_stall,
   input wire logic section_read_block,
   input wire logic flash_erase_strobe,
   input wire logic flash_write_strobe,
   input wire logic [PAGE_BITS-1:0] flash_page
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   int stall_len;

   // Length of the running stall, read when it ends
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_len <= 0;
      end else begin
         stall_len <= cpu_stall ? stall_len + 1 : 0;
      end
   end

   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_error_reads_zero: assert property (pready && pslverr |-> prdata == 0)
      else $error("refused access returned data");
   a_stall_no_read_while_write_section_page: assert property (
      cpu_stall |-> flash_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
      else $error("stall for a page outside the locked section");
   a_stall_page_held: assert property (
      cpu_stall && $past(cpu_stall) |-> $stable(flash_page))
      else $error("page changed during stall");
   a_prog_length: assert property (
      $fell(cpu_stall) |-> stall_len >= PROG_CYCLES - 2
      && stall_len <= PROG_CYCLES + 2)
      else $error("programming time out of range");
   a_erase_pulse: assert property (
      flash_erase_strobe |=> !flash_erase_strobe)
      else $error("erase strobe longer than a cycle");
   a_write_pulse: assert property (
      flash_write_strobe |=> !flash_write_strobe)
      else $error("write strobe longer than a cycle");
   a_one_operation: assert property (
      !(flash_erase_strobe && flash_write_strobe))
      else $error("erase and write ended together");
   a_end_blocked: assert property (
      flash_erase_strobe || flash_write_strobe |->
      cpu_stall || $past(cpu_stall) || section_read_block)
      else $error("section not blocked at end of programming");
endmodule // fsps_seq_chk

bind fsps_sequencer fsps_seq_chk #(.PAGE_BITS(PAGE_BITS),
   .NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE), .PROG_CYCLES(PROG_CYCLES))
   i_fsps_seq_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cpu_stall(cpu_stall),
   .section_read_block(section_read_block),
   .flash_erase_strobe(flash_erase_strobe),
   .flash_write_strobe(flash_write_strobe), .flash_page(flash_page));

`default_nettype wire

// ==== tb/tb_flash_self_program_sequencer.sv ====
// Self-checking bench for the flash self-program sequencer.
// Assumes fsps_consts.vh on the include path; short program time.
`timescale 1ns/1ps
`default_nettype none
`include "fsps_consts.vh"

module tb_flash_self_program_sequencer;
   localparam int PROG = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic eeprom_write_busy, cpu_stall, section_read_block, irq, fe, fw;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v, d;
   logic [6:0] flash_page;
   logic [31:0] fuse_tab [4];
   int bad_count, samples_checked, seed, lock_model, wcount, n0, s;

   fsps_sequencer #(.PROG_CYCLES(PROG)) i_fsps_sequencer (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .eeprom_write_busy(eeprom_write_busy),
      .cpu_stall(cpu_stall), .section_read_block(section_read_block),
      .completion_irq(irq), .flash_erase_strobe(fe),
      .flash_write_strobe(fw), .flash_page(flash_page));
   fsps_cpu_model i_fsps_cpu_model (.pclk(pclk), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   // Clock and write strobe count
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (fw === 1'b1) wcount <= wcount + 1;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic print_verdict();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a,
         input logic [31:0] dd, output logic [31:0] r);
      logic e, ok;
      i_fsps_cpu_model.xfer(w, a, dd, r, e, ok);
      if (!ok) begin
         bad_count++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] dd);
      logic [31:0] r;
      acc(1'b1, a, dd, r);
   endtask
   // Control pattern, then the instruction straight after it
   task automatic spm(input logic ie, input logic [4:0] p,
         input logic [1:0] c);
      wr(`FSPS_ADDR_CTRL, {24'h0, ie, 2'h0, p});
      wr(`FSPS_ADDR_CMD, {30'h0, c});
   endtask
   task automatic wait_done();
      int n;
      logic [31:0] r;
      n = 0;
      r = 32'h1;
      while (r[0] !== 1'b0 && n < 40) begin
         acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, r);
         n++;
      end
      if (r[0] !== 1'b0) begin
         bad_count++;
         print_verdict();
      end
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin : main
      logic e, ok;
      presetn = 1'b0;
      eeprom_write_busy = 1'b0;
      wcount = 0;
      seed = 32'hEF999A14;
      lock_model = 32'h3F;
      fuse_tab = '{32'hFF, 32'hFF, 32'hFF, 32'hFF};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
      chk(v, 32'h0);
      acc(1'b0, `FSPS_ADDR_FUSE, 32'h0, v);
      chk(v, 32'hFFFFFF);
      i_fsps_cpu_model.xfer(1'b0, 12'h020, 32'h0, v, e, ok);
      chk({30'h0, e, ok}, 32'h3);
      // Fuse and lock bytes by pointer
      for (int i = 0; i < 4; i++) begin
         wr(`FSPS_ADDR_PTR, 32'(i));
         spm(1'b0, `FSPS_PAT_LOCK, `FSPS_CMD_LOAD);
         acc(1'b0, `FSPS_ADDR_LPMD, 32'h0, v);
         chk(v, fuse_tab[i]);
         acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
         chk(v, 32'h0);
      end
      // Undefined patterns leave the control bits clear
      foreach (fuse_tab[i]) begin
         wr(`FSPS_ADDR_CTRL, {27'h0, 5'h07 + 5'(i * 4)});
         acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
         chk(v, 32'h0);
      end
      // Enable with no instruction lapses
      wr(`FSPS_ADDR_CTRL, 32'h01);
      repeat (5) @(posedge pclk);
      acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
      chk(v, 32'h0);
      // Random word into a random slot, read back low byte
      s = ($random(seed) & 31) | 1; // Odd slot, slot 0 comes later
      d = $random(seed) & 32'hFFFF;
      wr(`FSPS_ADDR_PTR, 32'(s << 1));
      wr(`FSPS_ADDR_DATA, d);
      spm(1'b0, `FSPS_PAT_LOAD, `FSPS_CMD_STORE);
      acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
      chk(v, 32'h0);
      wr(`FSPS_ADDR_CMD, {30'h0, `FSPS_CMD_LOAD});
      acc(1'b0, `FSPS_ADDR_LPMD, 32'h0, v);
      chk(v, d & 32'hFF);
      // Erase in the locked section halts the CPU
      wr(`FSPS_ADDR_PTR, 32'h1840);
      spm(1'b1, `FSPS_PAT_ERASE, `FSPS_CMD_STORE);
      @(negedge pclk);
      chk({31'h0, cpu_stall}, 32'h1);
      chk({25'h0, flash_page}, 32'h61);
      acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
      chk(v, 32'h83);
      wait_done();
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, cpu_stall}, 32'h0);
      // Erase, load and write in the open section
      wr(`FSPS_ADDR_PTR, 32'hC0);
      spm(1'b0, `FSPS_PAT_ERASE, `FSPS_CMD_STORE);
      wait_done();
      acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
      chk(v, 32'h40);
      chk({31'h0, section_read_block}, 32'h1);
      spm(1'b0, `FSPS_PAT_LOAD, `FSPS_CMD_STORE);
      n0 = wcount;
      spm(1'b0, `FSPS_PAT_WRITE, `FSPS_CMD_STORE);
      @(negedge pclk);
      chk({31'h0, cpu_stall}, 32'h0);
      wait_done();
      chk(32'(wcount - n0), 32'h1);
      spm(1'b0, `FSPS_PAT_REEN, `FSPS_CMD_STORE);
      acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
      chk(v, 32'h0);
      // A second write without erase is refused
      n0 = wcount;
      spm(1'b0, `FSPS_PAT_WRITE, `FSPS_CMD_STORE);
      repeat (PROG + 5) @(posedge pclk);
      chk(32'(wcount - n0), 32'h0);
      // EEPROM busy blocks control writes, drops loaded words
      spm(1'b0, `FSPS_PAT_LOAD, `FSPS_CMD_STORE);
      eeprom_write_busy <= 1'b1;
      repeat (4) @(posedge pclk);
      wr(`FSPS_ADDR_CTRL, 32'h09);
      acc(1'b0, `FSPS_ADDR_CTRL, 32'h0, v);
      chk(v, 32'h0);
      acc(1'b0, `FSPS_ADDR_STAT, 32'h0, v);
      chk(v, 32'h4);
      wr(`FSPS_ADDR_CMD, {30'h0, `FSPS_CMD_LOAD});
      acc(1'b0, `FSPS_ADDR_LPMD, 32'h0, v);
      chk(v, 32'hFF);
      eeprom_write_busy <= 1'b0;
      repeat (4) @(posedge pclk);
      // Program random boot lock bits, ones in the spare bits
      d = ($random(seed) & 32'h3C) | 32'hC3;
      wr(`FSPS_ADDR_DATA, d);
      wr(`FSPS_ADDR_PTR, 32'h1);
      spm(1'b0, `FSPS_PAT_LOCK, `FSPS_CMD_STORE);
      wait_done();
      lock_model = lock_model & (d | 32'h3);
      acc(1'b0, `FSPS_ADDR_LOCK, 32'h0, v);
      chk(v, 32'(lock_model));
      spm(1'b0, `FSPS_PAT_LOCK, `FSPS_CMD_LOAD);
      acc(1'b0, `FSPS_ADDR_LPMD, 32'h0, v);
      chk(v, 32'(lock_model | 32'hC0));
      print_verdict();
   end
endmodule // tb_flash_self_program_sequencer

`default_nettype wire
